// ---- logic/dual_core_interrupt_priority.sv ----
// two per-core interrupt priority controllers with shared external lines
`timescale 1ns/1ps
`include "dual_core_interrupt_priority_map.svh"
module dual_core_interrupt_priority
  import intprio_pkg::*;
#(
  parameter int CORES = 2,
  parameter int NSRC  = `IP_NUM_SOURCES
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [3:0]            extRequestN,
  input  wire logic [CORES-1:0]      prioWrite,
  input  wire reg_sel_t [CORES-1:0]  prioSel,
  input  wire logic [CORES-1:0][23:0] prioWData,
  input  wire logic [CORES-1:0][7:0] nmiReq,
  input  wire logic [CORES-1:0][7:0] dmaReq,
  input  wire logic [CORES-1:0][7:0] esaiReq,
  input  wire logic [CORES-1:0][5:0] hostReq,
  input  wire logic [CORES-1:0][5:0] timerReq,
  input  wire logic [CORES-1:0][7:0] esai2Req,
  input  wire logic [CORES-1:0][17:0] spdifReq,
  input  wire logic [CORES-1:0][7:0] asrcReq,
  input  wire logic [CORES-1:0][2:0] linkReq,
  input  wire logic [CORES-1:0]      ackValid,
  input  wire logic [CORES-1:0][6:0] ackSource,
  output logic      [CORES-1:0][23:0] coreRegA,
  output logic      [CORES-1:0][23:0] coreRegB,
  output logic      [CORES-1:0][23:0] periphRegA,
  output logic      [CORES-1:0][23:0] periphRegB,
  output logic      [CORES-1:0]      reqValid,
  output logic      [CORES-1:0][1:0] reqLevel,
  output logic      [CORES-1:0][6:0] reqSource,
  output logic      [CORES-1:0]      nmiValid,
  output logic      [CORES-1:0][2:0] nmiSource
);

  // two-bit field of a packed priority register
  function automatic level_code_t fieldOf(input logic [23:0] r, input int idx);
    fieldOf = r[2*idx +: 2];
  endfunction

  // code 1..3 means level 0..2; code 0 never wins the arbiter
  function automatic logic [1:0] codeToLevel(input level_code_t code);
    codeToLevel = code - 2'h1;
  endfunction

  genvar c;
  generate
    // each core owns a full copy of registers and arbiter
    for (c = 0; c < CORES; c++) begin : gCore

      logic [23:0] coreA_reg;
      logic [3:0]  coreB_reg;
      logic [23:0] periphA_reg;
      logic [1:0]  periphB_reg;

      logic [3:0]  extEdge;
      logic [3:0]  extPend;
      logic [3:0]  extClr;
      level_code_t lvl  [NSRC];
      logic        pend [NSRC];
      level_code_t bestCode;
      source_id_t  bestIdx;
      logic        nmiAny;
      logic [2:0]  nmiIdx;

      logic        reqValid_reg;
      logic [1:0]  reqLevel_reg;
      source_id_t  reqSource_reg;
      logic        nmiValid_reg;
      logic [2:0]  nmiSource_reg;

      // software writes; unimplemented slots are not stored and read zero
      always_ff @(posedge clk) begin
        if (rst) begin
          coreA_reg   <= `IP_CORE_A_RESET;
          coreB_reg   <= `IP_CORE_B_RESET;
          periphA_reg <= `IP_PERIPH_A_RESET;
          periphB_reg <= `IP_PERIPH_B_RESET;
        end else if (prioWrite[c]) begin
          unique case (prioSel[c])
            SEL_CORE_A:   coreA_reg   <= prioWData[c];
            SEL_CORE_B:   coreB_reg   <= prioWData[c][3:0];
            SEL_PERIPH_A: periphA_reg <= prioWData[c];
            SEL_PERIPH_B: periphB_reg <= prioWData[c][1:0];
          endcase
        end
      end

      assign coreRegA[c]   = coreA_reg;
      assign coreRegB[c]   = {20'h00000, coreB_reg};
      assign periphRegA[c] = periphA_reg;
      assign periphRegB[c] = {22'h000000, periphB_reg};

      // an accepted external line drops its edge latch
      for (genvar e = 0; e < 4; e++) begin : gExt
        assign extEdge[e] = coreA_reg[e*`IP_EXT_FIELD_W + `IP_EXT_TRIG_BIT];
        assign extClr[e]  = ackValid[c] && (ackSource[c] == 7'(`IP_BASE_EXT + e));
      end

      // both cores sense the very same pins
      ext_request_sense #(
        .LINES (4)
      ) uSense (
        .clk      (clk),
        .rst      (rst),
        .lineN    (extRequestN),
        .edgeMode (extEdge),
        .clrPend  (extClr),
        .pending  (extPend)
      );

      // source table in fixed rank order, index 0 highest
      always_comb begin
        for (int i = 0; i < NSRC; i++) begin
          lvl[i]  = 2'h0;
          pend[i] = 1'b0;
        end
        for (int e = 0; e < 4; e++) begin
          lvl[`IP_BASE_EXT + e]  = coreA_reg[e*`IP_EXT_FIELD_W +: 2];
          pend[`IP_BASE_EXT + e] = extPend[e];
        end
        // split loops keep every part-select inside its register
        for (int d = 0; d < `IP_DMA_A_COUNT; d++) begin
          lvl[`IP_BASE_DMA + d] = coreA_reg[`IP_DMA_A_POS + 2*d +: 2];
        end
        for (int d = 0; d < `IP_DMA_B_COUNT; d++) begin
          lvl[`IP_BASE_DMA + `IP_DMA_A_COUNT + d] = coreB_reg[2*d +: 2];
        end
        for (int d = 0; d < 8; d++) begin
          pend[`IP_BASE_DMA + d] = dmaReq[c][d];
        end
        for (int s = 0; s < 8; s++) begin
          // receive half then transmit half
          lvl[`IP_BASE_PRIMARY_AUDIO_SERIAL_PORT + s]  = fieldOf(periphA_reg,
                                            s < 4 ? `IP_PA_PRIMARY_AUDIO_SERIAL_PORT_RX : `IP_PA_PRIMARY_AUDIO_SERIAL_PORT_TX);
          pend[`IP_BASE_PRIMARY_AUDIO_SERIAL_PORT + s] = esaiReq[c][s];
          // secondary port follows the timers
          lvl[`IP_BASE_ESAI2 + s]  = fieldOf(periphA_reg,
                                             s < 4 ? `IP_PA_ESAI2_RX : `IP_PA_ESAI2_TX);
          pend[`IP_BASE_ESAI2 + s] = esai2Req[c][s];
          lvl[`IP_BASE_SAMPLE_RATE_CONVERTER + s]  = fieldOf(periphA_reg,
                                            s < `IP_SAMPLE_RATE_CONVERTER_OUT_COUNT ? `IP_PA_SAMPLE_RATE_CONVERTER_OUT
                                                                   : `IP_PA_SAMPLE_RATE_CONVERTER_IN);
          pend[`IP_BASE_SAMPLE_RATE_CONVERTER + s] = asrcReq[c][s];
        end
        for (int s = 0; s < 6; s++) begin
          lvl[`IP_BASE_HOST + s]   = fieldOf(periphA_reg, `IP_PA_HOST);
          pend[`IP_BASE_HOST + s]  = hostReq[c][s];
          lvl[`IP_BASE_TIMER + s]  = fieldOf(periphA_reg, `IP_PA_TIMER);
          pend[`IP_BASE_TIMER + s] = timerReq[c][s];
        end
        for (int s = 0; s < 18; s++) begin
          // receive block then the four trailing sources
          lvl[`IP_BASE_SPDIF + s]  = fieldOf(periphA_reg,
                                             s < `IP_SPDIF_RX_COUNT ? `IP_PA_SPDIF_RX
                                                                    : `IP_PA_SPDIF_TX);
          pend[`IP_BASE_SPDIF + s] = spdifReq[c][s];
        end
        // link request and acknowledge, access error, always active
        lvl[`IP_BASE_LINK + 0]  = fieldOf(periphA_reg, `IP_PA_LINK);
        pend[`IP_BASE_LINK + 0] = linkReq[c][0];
        lvl[`IP_BASE_LINK + 1]  = fieldOf(periphA_reg, `IP_PA_LINK);
        pend[`IP_BASE_LINK + 1] = linkReq[c][1];
        lvl[`IP_BASE_LINK + 2]  = fieldOf(periphA_reg, `IP_PA_ACC_ERR);
        pend[`IP_BASE_LINK + 2] = linkReq[c][2];
        lvl[`IP_BASE_LINK + 3]  = periphB_reg;
        pend[`IP_BASE_LINK + 3] = 1'b1;
      end

      // strict compare keeps the earlier, higher-ranked source on a tie
      always_comb begin
        bestCode = 2'h0;
        bestIdx  = 7'h00;
        for (int i = 0; i < NSRC; i++) begin
          if (pend[i] && (lvl[i] > bestCode)) begin
            bestCode = lvl[i];
            bestIdx  = 7'(i);
          end
        end
      end

      // non-maskable sources need no field; bit 0 is the highest
      always_comb begin
        nmiAny = 1'b0;
        nmiIdx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
          if (nmiReq[c][i]) begin
            nmiAny = 1'b1;
            nmiIdx = 3'(i);
          end
        end
      end

      // registered so every core-facing output is a flop
      always_ff @(posedge clk) begin
        if (rst) begin
          reqValid_reg  <= 1'b0;
          reqLevel_reg  <= 2'h0;
          reqSource_reg <= 7'h00;
        end else begin
          reqValid_reg  <= (bestCode != 2'h0);
          reqLevel_reg  <= (bestCode != 2'h0) ? codeToLevel(bestCode) : 2'h0;
          reqSource_reg <= bestIdx;
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          nmiValid_reg  <= 1'b0;
          nmiSource_reg <= 3'h0;
        end else begin
          nmiValid_reg  <= nmiAny;
          nmiSource_reg <= nmiIdx;
        end
      end

      assign reqValid[c]  = reqValid_reg;
      assign reqLevel[c]  = reqLevel_reg;
      assign reqSource[c] = reqSource_reg;
      assign nmiValid[c]  = nmiValid_reg;
      assign nmiSource[c] = nmiSource_reg;
    end
  endgenerate

endmodule

// ---- common/dual_core_interrupt_priority_map.svh ----
// register layout, source ranking and reset constants of the interrupt priority controller
//
// Contract
// - two independent controllers, one per core, each with its own registers
// - core register A holds four external line fields and DMA channels 0..5
// - peripheral register A holds twelve peripheral priority fields
// - core register B has twelve DMA field slots; only channels 6 and 7 exist
// - peripheral register B has twelve field slots; only slot 0 reaches a source
// - two-bit field: 0 disables, 1/2/3 enable at level 0/1/2
// - external field: low two bits as top bit selects negative edge
// - level 3: reset, stack, illegal, debug, trap, ext nmi, dma stall, link nmi
// - equal level: lines A..D first, then DMA channels 0..7 ascending
// - primary port: rx exc, rx even, rx data, rx last, tx exc, tx last, tx even, tx data
// - host port: bus err, rx overrun, tx underrun, rx full, tx data, rx not empty
// - timers 0..2 overflow then compare; secondary port rx then tx groups
// - s/pdif receive sources in their fixed fourteen-step order
// - then lock acquired, tx under/overrun, tx resync, tx fifo empty
// - converter: wait, overload, out C, B, A, in C, B, A
// - lowest: link request, link acknowledge, access error, always active
// - external lines are shared pins feeding both controllers
`ifndef DUAL_CORE_INTERRUPT_PRIORITY_MAP_SVH
`define DUAL_CORE_INTERRUPT_PRIORITY_MAP_SVH

`define IP_CORE_A_RESET    24'h000000
`define IP_CORE_B_RESET    4'h0
`define IP_PERIPH_A_RESET  24'h000000
`define IP_PERIPH_B_RESET  2'h0

`define IP_EXT_FIELD_W     3
`define IP_EXT_TRIG_BIT    2
`define IP_DMA_A_POS       12
`define IP_DMA_A_COUNT     6
`define IP_DMA_B_COUNT     2

`define IP_PA_PRIMARY_AUDIO_SERIAL_PORT_RX      0
`define IP_PA_PRIMARY_AUDIO_SERIAL_PORT_TX      1
`define IP_PA_HOST         2
`define IP_PA_TIMER        3
`define IP_PA_ESAI2_RX     4
`define IP_PA_ESAI2_TX     5
`define IP_PA_SPDIF_RX     6
`define IP_PA_SPDIF_TX     7
`define IP_PA_SAMPLE_RATE_CONVERTER_OUT     8
`define IP_PA_SAMPLE_RATE_CONVERTER_IN      9
`define IP_PA_LINK         10
`define IP_PA_ACC_ERR      11
`define IP_PB_ALWAYS       0

`define IP_BASE_EXT        0
`define IP_BASE_DMA        4
`define IP_BASE_PRIMARY_AUDIO_SERIAL_PORT       12
`define IP_BASE_HOST       20
`define IP_BASE_TIMER      26
`define IP_BASE_ESAI2      32
`define IP_BASE_SPDIF      40
`define IP_BASE_SAMPLE_RATE_CONVERTER       58
`define IP_BASE_LINK       66
`define IP_NUM_SOURCES     70

`define IP_SPDIF_RX_COUNT  14
`define IP_SAMPLE_RATE_CONVERTER_OUT_COUNT  5

`endif

// ---- common/intprio_pkg.sv ----
// types shared by the interrupt priority controller
package intprio_pkg;

  typedef enum logic [1:0] {
    SEL_CORE_A   = 2'b00,
    SEL_CORE_B   = 2'b01,
    SEL_PERIPH_A = 2'b10,
    SEL_PERIPH_B = 2'b11
  } reg_sel_t;

  typedef logic [1:0] level_code_t;
  typedef logic [6:0] source_id_t;

endpackage

// ---- logic/ext_request_sense.sv ----
// sensing of the active-low external request lines for one controller
`timescale 1ns/1ps
module ext_request_sense #(
  parameter int LINES = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [LINES-1:0] lineN,
  input  wire logic [LINES-1:0] edgeMode,
  input  wire logic [LINES-1:0] clrPend,
  output logic      [LINES-1:0] pending
);

  logic [LINES-1:0] prev_reg;
  logic [LINES-1:0] latch_reg;

  // idle lines sit high, so no false edge right after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= '1;
    end else begin
      prev_reg <= lineN;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : gLine
      always_ff @(posedge clk) begin
        if (rst) begin
          latch_reg[g] <= 1'b0;
        end else if (!edgeMode[g]) begin
          latch_reg[g] <= 1'b0;
        end else if (prev_reg[g] && !lineN[g]) begin
          latch_reg[g] <= 1'b1;  // set beats a same-cycle accept
        end else if (clrPend[g]) begin
          latch_reg[g] <= 1'b0;
        end
      end
      assign pending[g] = edgeMode[g] ? latch_reg[g] : !lineN[g];
    end
  endgenerate

endmodule

// ---- dv/dual_core_interrupt_priority_props.sv ----
// concurrent checks on the interrupt priority controller ports
`timescale 1ns/1ps
module dual_core_interrupt_priority_props
  import intprio_pkg::*;
#(
  parameter int CORES = 2
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [3:0]             extRequestN,
  input wire logic [CORES-1:0]       prioWrite,
  input wire reg_sel_t [CORES-1:0]   prioSel,
  input wire logic [CORES-1:0][23:0] prioWData,
  input wire logic [CORES-1:0][7:0]  nmiReq,
  input wire logic [CORES-1:0]       ackValid,
  input wire logic [CORES-1:0][23:0] coreRegA,
  input wire logic [CORES-1:0][23:0] coreRegB,
  input wire logic [CORES-1:0][23:0] periphRegA,
  input wire logic [CORES-1:0][23:0] periphRegB,
  input wire logic [CORES-1:0]       reqValid,
  input wire logic [CORES-1:0][1:0]  reqLevel,
  input wire logic [CORES-1:0]       nmiValid,
  input wire logic [CORES-1:0][2:0]  nmiSource
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic armEdge = coreRegA[0][2:0] == 3'h7 && !ackValid[0];
  wire logic armLvl = coreRegA[0][2:0] == 3'h3;
  wire logic allOff = (coreRegA[0] | coreRegB[0] | periphRegA[0] | periphRegB[0]) == 24'h0;
  function automatic logic [2:0] lowBit(logic [7:0] v);
    lowBit = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (v[i]) lowBit = 3'(i);
  endfunction
  sequence sFall;
    armEdge && extRequestN[0] ##1 armEdge && !extRequestN[0] ##1 armEdge;
  endsequence
  sequence sLow;
    (armLvl && !extRequestN[0]) [*2];
  endsequence
  chk_reset_quiet: assert property ($fell(rst)
    |-> !reqValid[0] && coreRegA[0] == 24'h0) else $error("outputs not cleared by reset");
  chk_core_b_mask: assert property (prioWrite[0] && prioSel[0] == SEL_CORE_B
    |=> coreRegB[0] == {20'h0, $past(prioWData[0][3:0])}) else $error("core reg b wrong");
  chk_core_a_write: assert property (prioWrite[1] && prioSel[1] == SEL_CORE_A
    |=> coreRegA[1] == $past(prioWData[1])) else $error("core reg a wrong");
  chk_periph_b_mask: assert property (prioWrite[0] && prioSel[0] == SEL_PERIPH_B
    |=> periphRegB[0] == {22'h0, $past(prioWData[0][1:0])}) else $error("periph reg b wrong");
  chk_nmi_rank: assert property (nmiReq[0] != 8'h0
    |=> nmiValid[0] && nmiSource[0] == lowBit($past(nmiReq[0]))) else $error("nmi rank wrong");
  chk_all_off: assert property (allOff [*2] |=> !reqValid[0])
    else $error("request from disabled source");
  chk_edge_latch: assert property (sFall |=> reqValid[0] && reqLevel[0] == 2'h2)
    else $error("falling edge not held");
  chk_level_follow: assert property (sLow |=> reqValid[0] && reqLevel[0] == 2'h2)
    else $error("low line not presented");
endmodule
bind dual_core_interrupt_priority dual_core_interrupt_priority_props #(.CORES(CORES)) u_props (
  .clk(clk), .rst(rst), .extRequestN(extRequestN), .prioWrite(prioWrite), .prioSel(prioSel),
  .prioWData(prioWData), .nmiReq(nmiReq), .ackValid(ackValid), .coreRegA(coreRegA),
  .coreRegB(coreRegB), .periphRegA(periphRegA), .periphRegB(periphRegB),
  .reqValid(reqValid), .reqLevel(reqLevel), .nmiValid(nmiValid), .nmiSource(nmiSource));

// ---- dv/core_ack_model.sv ----
// core-side model that accepts whatever request is presented
`timescale 1ns/1ps
module core_ack_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ackOn,
  input  wire logic       reqValid,
  input  wire logic [6:0] reqSource,
  output logic            ackValid,
  output logic [6:0]      ackSource
);
  // never two pulses in a row; the next pulse still answers the request registered before the latch cleared
  always_ff @(posedge clk) begin
    if (rst) begin
      ackValid <= 1'b0;
      ackSource <= 7'h00;
    end else begin
      ackValid <= ackOn && reqValid && !ackValid;
      ackSource <= reqSource;
    end
  end
endmodule

// ---- dv/dual_core_interrupt_priority_test.sv ----
// self-checking bench for the two-core interrupt priority controller
`timescale 1ns/1ps
module dual_core_interrupt_priority_test;
  import intprio_pkg::*;
  typedef struct {int due; int c; int k; logic [23:0] v;} note_t;
  logic             clk = 1'b0, rst = 1'b1, ackOn = 1'b0, ack0V;
  logic [6:0]       ack0S;
  logic [3:0]       extN = 4'hf;
  logic [1:0]       wr = 2'h0, rv, nv;
  reg_sel_t [1:0]   sel;
  logic [1:0][23:0] wd = '0, d, rA, rB, pA, pB;
  logic [1:0][7:0]  nmi = '0;
  logic [1:0][83:0] src = '0;  // spare top bits take the widest group slice
  logic [1:0][1:0]  rl;
  logic [1:0][6:0]  rs;
  logic [1:0][2:0]  ns;
  logic [17:0]      r;
  note_t            q[$];
  int               cyc = 0, nFail = 0, checkCount = 0;
  int               gb[7] = '{12, 20, 26, 32, 40, 58, 66};
  int               gw[7] = '{8, 6, 6, 8, 18, 8, 3};
  integer           seed = 32'hd984db3c;
  dual_core_interrupt_priority u_dual_core_interrupt_priority (
    .clk(clk), .rst(rst), .extRequestN(extN), .prioWrite(wr), .prioSel(sel),
    .prioWData(wd), .nmiReq(nmi), .dmaReq({src[1][11:4], src[0][11:4]}),
    .esaiReq({src[1][19:12], src[0][19:12]}), .hostReq({src[1][25:20], src[0][25:20]}),
    .timerReq({src[1][31:26], src[0][31:26]}), .esai2Req({src[1][39:32], src[0][39:32]}),
    .spdifReq({src[1][57:40], src[0][57:40]}), .asrcReq({src[1][65:58], src[0][65:58]}),
    .linkReq({src[1][68:66], src[0][68:66]}), .ackValid({1'b0, ack0V}),
    .ackSource({7'h00, ack0S}), .coreRegA(rA), .coreRegB(rB), .periphRegA(pA),
    .periphRegB(pB), .reqValid(rv), .reqLevel(rl), .reqSource(rs), .nmiValid(nv),
    .nmiSource(ns));
  core_ack_model u_core_ack_model (.clk(clk), .rst(rst), .ackOn(ackOn), .reqValid(rv[0]),
    .reqSource(rs[0]), .ackValid(ack0V), .ackSource(ack0S));
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [23:0] rq(logic v, logic [1:0] l, logic [6:0] s);
    return {14'h0, v, l, s};
  endfunction
  function automatic int lowest(logic [17:0] v);
    lowest = 0;
    for (int i = 17; i >= 0; i--)
      if (v[i]) lowest = i;
  endfunction
  function automatic logic [23:0] look(int c, int k);
    case (k)
      0: look = {10'h0, nv[c], ns[c], rv[c], rl[c], rs[c]};
      1: look = rA[c];
      2: look = rB[c];
      3: look = pA[c];
      default: look = pB[c];
    endcase
  endfunction
  task automatic close_out;
    $display("compares %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(logic [23:0] seen, logic [23:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nFail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(negedge clk) begin
    if (q.size() > 0 && q[0].due <= cyc) begin
      check(look(q[0].c, q[0].k), q[0].v);
      void'(q.pop_front());
    end
  end
  task automatic put(int c, int k, logic [23:0] v);
    q.push_back('{cyc + 2, c, k, v});
  endtask
  task automatic wrReg(int c, int k, logic [23:0] v);
    sel[c] = reg_sel_t'(k);
    wd[c] = v;
    wr[c] = 1'b1;
    @(negedge clk);
    wr[c] = 1'b0;
    // spare cycle keeps the strobe low between back-to-back writes
    @(negedge clk);
  endtask
  // results are due two edges on; the bound covers a full queue
  task automatic drain;
    for (int i = 0; i < 20 && q.size() > 0; i++) @(negedge clk);
    if (q.size() > 0) begin
      nFail++;
      close_out();
    end
  endtask
  initial begin
    sel[0] = SEL_CORE_A;
    sel[1] = SEL_CORE_A;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    put(0, 0, rq(0, 2'h0, 7'h00));
    drain();
    for (int i = 0; i < 8; i++) begin
      nmi[0] = 8'($random(seed)) | 8'h80;
      nmi[1] = 8'h01 << i;
      put(0, 0, {10'h0, 1'b1, 3'(lowest(18'(nmi[0]))), 10'h0});
      put(1, 0, {10'h0, 1'b1, 3'(i), 10'h0});
      drain();
    end
    nmi = '0;
    $display("nmi test done");
    for (int c = 0; c < 2; c++) begin
      d[c] = 24'($random(seed));
      for (int k = 0; k < 4; k++) wrReg(c, k, d[c]);
    end
    for (int c = 0; c < 2; c++) begin
      put(c, 1, d[c]);
      put(c, 2, {20'h0, d[c][3:0]});
      put(c, 3, d[c]);
      put(c, 4, {22'h0, d[c][1:0]});
    end
    drain();
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 4; k++) wrReg(c, k, 24'h0);
    $display("register test done");
    src[0][4] = 1'b1;
    src[1][4] = 1'b1;
    for (int v = 0; v < 4; v++) begin
      for (int c = 0; c < 2; c++) wrReg(c, 0, 24'(v) << 12);
      for (int c = 0; c < 2; c++)
        put(c, 0, v == 0 ? rq(0, 0, 0) : rq(1, 2'(v - 1), 7'h04));
      drain();
    end
    wrReg(0, 0, 24'haaa000);
    wrReg(0, 1, 24'h00000a);
    for (int i = 0; i < 6; i++) begin
      src[0][11:4] = 8'($random(seed)) | 8'h80;
      put(0, 0, rq(1, 2'h1, 7'(4 + lowest(18'(src[0][11:4])))));
      drain();
    end
    wrReg(0, 1, 24'h00000e);
    src[0][11:4] = 8'hff;
    put(0, 0, rq(1, 2'h2, 7'h0b));
    drain();
    src = '0;
    for (int k = 0; k < 2; k++) wrReg(0, k, 24'h0);
    $display("dma test done");
    wrReg(0, 2, 24'h555555);
    wrReg(0, 3, 24'h000001);
    put(0, 0, rq(1, 2'h0, 7'h45));
    drain();
    for (int g = 0; g < 7; g++) begin
      for (int b = 0; b < gw[g]; b++) begin
        r = (18'h3ffff << b) & ((18'h1 << gw[g]) - 18'h1);
        src[0][gb[g] +: 18] = r;
        put(0, 0, rq(1, 2'h0, 7'(gb[g] + b)));
        drain();
      end
      src = '0;
    end
    $display("ranking test done");
    for (int c = 0; c < 2; c++) wrReg(c, 0, 24'h000003);
    extN[0] = 1'b0;
    for (int c = 0; c < 2; c++) put(c, 0, rq(1, 2'h2, 7'h00));
    drain();
    extN[0] = 1'b1;
    put(0, 0, rq(1, 2'h0, 7'h45));
    put(1, 0, rq(0, 2'h0, 7'h00));
    drain();
    wrReg(0, 0, 24'h000007);
    @(negedge clk);
    extN[0] = 1'b0;
    @(negedge clk);
    extN[0] = 1'b1;
    put(0, 0, rq(1, 2'h2, 7'h00));
    drain();
    ackOn = 1'b1;
    repeat (6) @(negedge clk);
    put(0, 0, rq(1, 2'h0, 7'h45));
    drain();
    ackOn = 1'b0;
    $display("external line test done");
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    put(0, 4, 24'h0);
    put(0, 0, rq(0, 2'h0, 7'h00));
    drain();
    $display("second reset test done");
    close_out();
  end
endmodule
